/* logic/tuam_pkg.sv */
// Constants and types for the layer-4 entry matcher
package tuam_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] TUAM_OFF_CTRL = 12'h000;
    localparam logic [11:0] TUAM_OFF_SRC_LO = 12'h004;
    localparam logic [11:0] TUAM_OFF_SRC_HI = 12'h008;
    localparam logic [11:0] TUAM_OFF_DST_LO = 12'h00c;
    localparam logic [11:0] TUAM_OFF_DST_HI = 12'h010;
    localparam logic [11:0] TUAM_OFF_FLAGS = 12'h014;
    localparam logic [11:0] TUAM_OFF_STATUS = 12'h018;
    localparam logic [11:0] TUAM_OFF_HITCNT = 12'h01c;

    // ==========================================================
    // Field positions
    localparam int TUAM_CTRL_SRC_POS = 0;
    localparam int TUAM_CTRL_DST_POS = 2;
    localparam int TUAM_CTRL_EN_POS = 4;
    localparam int TUAM_FLAG_FIN_POS = 0;
    localparam int TUAM_FLAG_SYN_POS = 2;
    localparam int TUAM_FLAG_RST_POS = 4;
    localparam int TUAM_FLAG_PSH_POS = 6;
    localparam int TUAM_FLAG_ACK_POS = 8;
    localparam int TUAM_FLAG_URG_POS = 10;
    localparam int TUAM_NFLAGS = 6;

    // ==========================================================
    // Reset values
    localparam logic [31:0] TUAM_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] TUAM_PORT_RST = 16'h0000;
    localparam logic [11:0] TUAM_FLAGS_RST = 12'hfff;

    // ==========================================================
    // Encodings
    typedef enum logic [1:0] {
        TUAM_PORT_ANY = 2'b00,
        TUAM_PORT_SPECIFIC = 2'b01,
        TUAM_PORT_RANGE = 2'b10
    } tuam_port_mode_t;

    typedef enum logic [1:0] {
        TUAM_FLAG_CLEAR = 2'b00,
        TUAM_FLAG_SET = 2'b01,
        TUAM_FLAG_ANY = 2'b11
    } tuam_flag_mode_t;
endpackage : tuam_pkg

/* logic/tuam_matcher.sv */
// Layer-4 access_control_entry matcher with APB configuration
// How it works
// RULE1: Source mode any ignores the source port completely.
// RULE2: Source specific mode hits only when source port equals configured value.
// RULE3: Source range mode hits when port lies within inclusive low..high bounds.
// RULE4: Destination mode any ignores the destination port completely.
// RULE5: Destination specific mode hits only on equal destination port.
// RULE6: Destination range mode hits when port lies within inclusive bounds.
// RULE7: Finish setting 0 rejects finish set; setting 1 requires it.
// RULE8: Synchronize setting 0 rejects bit set; setting 1 requires it.
// RULE9: Push setting 0 rejects bit set; setting 1 requires it.
// RULE10: Acknowledge setting 0 rejects bit set; setting 1 requires it.
// RULE11: Urgent setting 0 rejects bit set; setting 1 requires it.
// RULE12: Any flag setting don't-care lets the bit take either value.
// RULE13: Hit is AND of all criteria; flags apply only to TCP frames.
// RULE14: Reset flag offers clear, set and don't-care like the others.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
module tuam_matcher (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frm_valid,
    input wire logic frm_is_tcp,
    input wire logic frm_is_l4,
    input wire logic [15:0] frm_src_port,
    input wire logic [15:0] frm_dst_port,
    input wire logic [5:0] frm_tcp_flags,
    output logic hit_valid,
    output logic entry_hit
);
    import tuam_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic entry_en;
        tuam_port_mode_t src_mode;
        tuam_port_mode_t dst_mode;
        logic [15:0] src_lo;
        logic [15:0] src_hi;
        logic [15:0] dst_lo;
        logic [15:0] dst_hi;
        logic [11:0] flag_cfg;
        logic hit_valid;
        logic entry_hit;
        logic last_hit;
        logic [31:0] hit_cnt;
        logic [31:0] prdata;
    } tuam_state_t;

    tuam_state_t state_reg;
    tuam_state_t state_next;

    // ==========================================================
    // Matching functions
    function automatic logic tuam_port_ok(input tuam_port_mode_t mode,
                                          input logic [15:0] port,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic ok;
        ok = 1'b0;
        case (mode)
            TUAM_PORT_ANY: ok = 1'b1;                                // RULE1 RULE4
            TUAM_PORT_SPECIFIC: ok = (port == lo);                   // RULE2 RULE5
            TUAM_PORT_RANGE: ok = (port >= lo) && (port <= hi);      // RULE3 RULE6
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : tuam_port_ok

    function automatic logic tuam_flag_ok(input logic [1:0] mode, input logic bit_val);
        logic ok;
        ok = 1'b0;
        case (mode)
            TUAM_FLAG_CLEAR: ok = !bit_val;  // RULE7 RULE8 RULE9 RULE10 RULE11 RULE14
            TUAM_FLAG_SET: ok = bit_val;     // RULE7 RULE8 RULE9 RULE10 RULE11 RULE14
            TUAM_FLAG_ANY: ok = 1'b1;        // RULE12
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction : tuam_flag_ok

    // ==========================================================
    // Combinational next state
    logic flags_ok;
    logic match;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    always_comb begin
        flags_ok = 1'b1;
        for (int i = 0; i < TUAM_NFLAGS; i++) begin
            flags_ok = flags_ok &
                tuam_flag_ok(state_reg.flag_cfg[2*i +: 2], frm_tcp_flags[i]);
        end
        match = state_reg.entry_en && frm_is_l4 &&
            tuam_port_ok(state_reg.src_mode, frm_src_port, state_reg.src_lo,
                         state_reg.src_hi) &&
            tuam_port_ok(state_reg.dst_mode, frm_dst_port, state_reg.dst_lo,
                         state_reg.dst_hi) &&
            (!frm_is_tcp || flags_ok);                               // RULE13
    end

    always_comb begin
        addr_ok = (paddr[1:0] == 2'b00) && (paddr <= TUAM_OFF_HITCNT);
        wr_en = psel && penable && pwrite;
        rd_en = psel && !penable && !pwrite;
        state_next = state_reg;
        state_next.hit_valid = frm_valid;
        state_next.entry_hit = frm_valid && match;
        if (frm_valid && match) begin
            state_next.last_hit = 1'b1;
            state_next.hit_cnt = state_reg.hit_cnt + 32'h0000_0001;
        end else if (frm_valid) begin
            state_next.last_hit = 1'b0;
        end
        if (wr_en) begin
            case (paddr)
                TUAM_OFF_CTRL: begin
                    state_next.src_mode = tuam_port_mode_t'(pwdata[TUAM_CTRL_SRC_POS +: 2]);
                    state_next.dst_mode = tuam_port_mode_t'(pwdata[TUAM_CTRL_DST_POS +: 2]);
                    state_next.entry_en = pwdata[TUAM_CTRL_EN_POS];
                end
                TUAM_OFF_SRC_LO: state_next.src_lo = pwdata[15:0];
                TUAM_OFF_SRC_HI: state_next.src_hi = pwdata[15:0];
                TUAM_OFF_DST_LO: state_next.dst_lo = pwdata[15:0];
                TUAM_OFF_DST_HI: state_next.dst_hi = pwdata[15:0];
                TUAM_OFF_FLAGS: state_next.flag_cfg = pwdata[11:0];
                TUAM_OFF_HITCNT: state_next.hit_cnt = 32'h0000_0000;
                default: ;
            endcase
        end
        if (rd_en) begin
            case (paddr)
                TUAM_OFF_CTRL: state_next.prdata = {27'h0, state_reg.entry_en,
                    state_reg.dst_mode, state_reg.src_mode};
                TUAM_OFF_SRC_LO: state_next.prdata = {16'h0, state_reg.src_lo};
                TUAM_OFF_SRC_HI: state_next.prdata = {16'h0, state_reg.src_hi};
                TUAM_OFF_DST_LO: state_next.prdata = {16'h0, state_reg.dst_lo};
                TUAM_OFF_DST_HI: state_next.prdata = {16'h0, state_reg.dst_hi};
                TUAM_OFF_FLAGS: state_next.prdata = {20'h0, state_reg.flag_cfg};
                TUAM_OFF_STATUS: state_next.prdata = {31'h0, state_reg.last_hit};
                TUAM_OFF_HITCNT: state_next.prdata = state_reg.hit_cnt;
                default: state_next.prdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.entry_en <= TUAM_CTRL_RST[TUAM_CTRL_EN_POS];
            state_reg.src_mode <= TUAM_PORT_ANY;
            state_reg.dst_mode <= TUAM_PORT_ANY;
            state_reg.src_lo <= TUAM_PORT_RST;
            state_reg.src_hi <= TUAM_PORT_RST;
            state_reg.dst_lo <= TUAM_PORT_RST;
            state_reg.dst_hi <= TUAM_PORT_RST;
            state_reg.flag_cfg <= TUAM_FLAGS_RST;
            state_reg.hit_valid <= 1'b0;
            state_reg.entry_hit <= 1'b0;
            state_reg.last_hit <= 1'b0;
            state_reg.hit_cnt <= 32'h0000_0000;
            state_reg.prdata <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bus answers one cycle after setup
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = state_reg.prdata;
    assign hit_valid = state_reg.hit_valid;
    assign entry_hit = state_reg.entry_hit;
endmodule : tuam_matcher

/* bench/tuam_matcher_asserts.sv */
// Assertion checker for the layer-4 entry matcher
`timescale 1ns/1ns
module tuam_matcher_chk (
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr, frm_valid, frm_is_tcp, frm_is_l4,
    input wire logic [15:0] frm_src_port, frm_dst_port,
    input wire logic [5:0] frm_tcp_flags,
    input wire logic hit_valid, entry_hit
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence frame_s; frm_valid; endsequence
    sequence answer_s; hit_valid; endsequence
    ans_follow_a: assert property (frame_s |=> answer_s) else $error("no answer");
    ans_cause_a: assert property (answer_s |-> $past(frm_valid)) else $error("stray answer");
    hit_qual_a: assert property (entry_hit |-> hit_valid) else $error("hit outside answer");
    hit_l4_a: assert property (entry_hit |-> $past(frm_is_l4)) else $error("non l4 hit");
    ready_high_a: assert property (psel && penable |-> pready) else $error("wait state");
    bad_addr_a: assert property (psel && penable && (paddr > 12'h01c || paddr[1:0] != 2'b00)
        |-> pslverr) else $error("unmapped accepted");
    good_addr_a: assert property (psel && penable && paddr <= 12'h01c && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped refused");
    err_read_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read gave data");
    rd_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
endmodule : tuam_matcher_chk
bind tuam_matcher tuam_matcher_chk tuam_matcher_chk_inst (.*);

/* bench/tuam_parser_model.sv */
// Behavioural frame header parser feeding the matcher
`timescale 1ns/1ns
module tuam_parser_model (
    input wire logic pclk,
    input wire logic go,
    input wire logic [39:0] req,
    output logic frm_valid,
    output logic frm_is_tcp,
    output logic frm_is_l4,
    output logic [15:0] frm_src_port,
    output logic [15:0] frm_dst_port,
    output logic [5:0] frm_tcp_flags
);
    logic [39:0] hdr = 40'h0;
    initial frm_valid = 1'b0;
    assign {frm_is_tcp, frm_is_l4, frm_src_port, frm_dst_port, frm_tcp_flags} = hdr;
    // Fields hold meaning only with the pulse; inverted otherwise
    always @(posedge pclk) begin
        frm_valid <= go;
        hdr <= go ? req : ~hdr;
    end
endmodule : tuam_parser_model

/* bench/tuam_matcher_test.sv */
// Self-checking bench for the layer-4 entry matcher
`timescale 1ns/1ns
module tuam_matcher_test;
    import tuam_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, err, e;
    logic pready, pslverr, hit_valid, entry_hit, frm_valid, frm_is_tcp, frm_is_l4;
    logic [11:0] paddr = 0, fl;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] frm_src_port, frm_dst_port, lo, hi;
    logic [5:0] frm_tcp_flags;
    logic [39:0] req = 0, r;
    logic [1:0] sm, dm;
    logic q[$];
    int bad_count = 0, num_checks = 0, hits;
    initial forever #50 pclk = ~pclk;
    tuam_matcher tuam_matcher_inst (.*);
    tuam_parser_model tuam_parser_model_inst (.*);
    task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", n, x, g);
        end
    endtask : cmp
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] d, input logic x);
        apb(a, 0, 0);
        cmp("prdata", d, rd);
        cmp("pslverr", x, err);
    endtask : rdc
    function automatic logic [15:0] pick();
        case ($urandom % 5)
            0: return lo;
            1: return hi;
            2: return 16'(lo - 1);
            3: return 16'(hi + 1);
            default: return 16'($urandom);
        endcase
    endfunction : pick
    function automatic logic ok(input logic [1:0] m, input logic [15:0] p);
        return m == TUAM_PORT_ANY || m == TUAM_PORT_SPECIFIC && p == lo
            || m == TUAM_PORT_RANGE && p >= lo && p <= hi;
    endfunction : ok
    function automatic logic fok(input logic [5:0] b);
        logic o = 1;
        for (int k = 0; k < 6; k++) begin
            if (fl[2*k+:2] == TUAM_FLAG_CLEAR && b[k] || fl[2*k+:2] == TUAM_FLAG_SET && !b[k]) o = 0;
        end
        return o;
    endfunction : fok
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    always @(negedge pclk) if (hit_valid === 1'b1) cmp("entry_hit", q.size() ? q.pop_front() : 1'bx,
        entry_hit);
    initial begin
        #1000000;
        bad_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(30722));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rdc(TUAM_OFF_CTRL, TUAM_CTRL_RST, 0);
        rdc(TUAM_OFF_FLAGS, 32'(TUAM_FLAGS_RST), 0);
        rdc(TUAM_OFF_DST_HI, 32'(TUAM_PORT_RST), 0);
        apb(12'h020, 1, 32'hffff_ffff);
        rdc(12'h020, 0, 1);
        rdc(12'h006, 0, 1);
        for (int i = 0; i < 45; i++) begin
            sm = 2'(i % 4);
            dm = 2'(i / 4 % 4);
            lo = i % 4 == 0 ? 16'h0000 : 16'($urandom);
            hi = i % 4 == 1 ? 16'hffff : 16'(lo + $urandom % 8);
            for (int k = 0; k < 6; k++) fl[2*k+:2] = 2'($urandom % 4);
            apb(TUAM_OFF_CTRL, 1, 32'({i != 0, dm, sm}));
            apb(TUAM_OFF_SRC_LO, 1, 32'(lo));
            apb(TUAM_OFF_SRC_HI, 1, 32'(hi));
            apb(TUAM_OFF_DST_LO, 1, 32'(lo));
            apb(TUAM_OFF_DST_HI, 1, 32'(hi));
            apb(TUAM_OFF_FLAGS, 1, 32'(fl));
            apb(TUAM_OFF_HITCNT, 1, 0);
            hits = 0;
            for (int f = 0; f < 8; f++) begin
                r = {2'($urandom), pick(), pick(), 6'($urandom)};
                e = i != 0 && r[38] && ok(sm, r[37:22]) && ok(dm, r[21:6]) && (!r[39] || fok(r[5:0]));
                q.push_back(e);
                hits += e;
                req <= r;
                go <= 1;
                @(posedge pclk);
            end
            go <= 0;
            repeat (4) @(posedge pclk);
            rdc(TUAM_OFF_HITCNT, hits, 0);
            rdc(TUAM_OFF_STATUS, e, 0);
        end
        cmp("pending", 0, q.size());
        end_of_test();
    end
endmodule : tuam_matcher_test
